// *** core/imsre_phase_gen.sv ***
// clock phase generator, restarted by hardware reset
`timescale 1ns/1ps

module imsre_phase_gen #(
  parameter int unsigned PHASES = imsre_pkg::PHASE_COUNT
) (
  // clock and reset
  input  wire logic clock,
  input  wire logic rst,
  // phase outputs
  output logic      phase_ff,
  output logic      phase_start_ff
);

  // ****************************************
  // phase counter
  // ****************************************
  logic [$clog2(PHASES+1)-1:0] cnt_ff;

  // reset restarts the count so phase 0 lines up with reset release
  always_ff @(posedge clock or posedge rst) begin
    if (rst) begin // [R6]
      cnt_ff         <= '0;
      phase_ff       <= imsre_pkg::PHASE_RST;
      phase_start_ff <= 1'h0;
    end else begin
      if (cnt_ff == ($clog2(PHASES+1))'(PHASES - 1)) begin
        cnt_ff <= '0;
      end else begin
        cnt_ff <= cnt_ff + 1'b1;
      end
      phase_start_ff <= (cnt_ff == ($clog2(PHASES+1))'(PHASES - 1));
      phase_ff       <= cnt_ff[0];
    end
  end

  // ****************************************
  // checks
  // ****************************************
  phase_restart_a: assert property (@(posedge clock) $fell(rst) |-> cnt_ff == '0) // [R6]
    else $error("phase counter not restarted by reset");

endmodule

// *** core/imsre_pkg.sv ***
// constants and types shared by the interrupt and mode control block
package imsre_pkg;

  // ****************************************
  // widths and reset values
  // ****************************************
  localparam int unsigned NUM_REQ      = 4;
  localparam int unsigned MODE_W       = 4;
  localparam logic [3:0]  OPMODE_RST   = 4'h0;
  localparam logic        PLL_EN_RST   = 1'h0;
  // pins idle high, so edge history starts deasserted
  localparam logic [3:0]  PIN_IDLE     = 4'hf;

  // ****************************************
  // clock phase generator
  // ****************************************
  localparam int unsigned PHASE_COUNT  = 2;
  localparam logic [0:0]  PHASE_RST    = 1'h0;

  // ****************************************
  // life cycle of the block
  // ****************************************
  typedef enum logic [1:0] {
    IMSRE_BOOT = 2'b01,
    IMSRE_RUN  = 2'b10
  } imsre_state_t;

endpackage

// *** core/imsre_top.sv ***
// interrupt and mode control: start-up mode capture, external requests, nmi, wake
`timescale 1ns/1ps
// What this block does
// (R1) Latch four mode pins at reset release
// (R2) After reset, mode pins become interrupt requests
// (R3) Requests are maskable, level or falling edge
// (R4) Request a wakes from stop or wait
// (R5) Requests b, c, d wake from wait
// (R6) Reset resets chip and phase generator
// (R7) System asserts reset after power up
// (R8) Pll select during reset sets pll enable
// (R9) Nmi falling edge raises unmaskable request
// (R10) Per-line mask, edge select, pending edge flags

module imsre_top (
  // clock and reset
  input  wire logic       clock,
  input  wire logic       rst,
  // shared mode / request pins, requests active low after reset
  input  wire logic       mode_select_a,
  input  wire logic       mode_select_b,
  input  wire logic       mode_select_c,
  input  wire logic       mode_select_d,
  input  wire logic       pll_initial_select,
  input  wire logic       nmi_n,
  // core side control
  input  wire logic [3:0] edge_select,
  input  wire logic [3:0] irq_mask,
  input  wire logic [3:0] irq_ack,
  input  wire logic       nmi_ack,
  input  wire logic       stop_state,
  input  wire logic       wait_state,
  // core side status
  output logic      [3:0] operating_mode_ff,
  output logic            pll_enable_ff,
  output logic      [3:0] irq_request_ff,
  output logic            nmi_request_ff,
  output logic            wake_ff,
  output logic            phase_ff,
  output logic            phase_start_ff
);

  // ****************************************
  // declarations
  // ****************************************
  imsre_pkg::imsre_state_t state_ff;
  imsre_pkg::imsre_state_t nxt_state;
  logic [3:0] ext_request_n;
  logic [3:0] prev_req_ff;
  logic [3:0] pend_ff;
  logic [3:0] nxt_pend;
  logic [3:0] req_fell;
  logic       prev_nmi_ff;
  logic       nmi_fell;
  logic       running;

  function automatic logic [3:0] fell4(input logic [3:0] prev, input logic [3:0] cur);
    fell4 = prev & ~cur;
  endfunction

  assign ext_request_n = {mode_select_d, mode_select_c, mode_select_b, mode_select_a};
  assign running       = (state_ff == imsre_pkg::IMSRE_RUN);
  assign req_fell      = fell4(prev_req_ff, ext_request_n);
  assign nmi_fell      = fell4({3'h0, prev_nmi_ff}, {3'h0, nmi_n}) != 4'h0;

  // ****************************************
  // life cycle
  // ****************************************
  // the system must hold rst after power up; all state below relies on it [R7]
  always_comb begin
    nxt_state = state_ff;
    case (state_ff)
      imsre_pkg::IMSRE_BOOT: begin
        nxt_state = imsre_pkg::IMSRE_RUN;
      end
      imsre_pkg::IMSRE_RUN: begin
        nxt_state = imsre_pkg::IMSRE_RUN;
      end
      default: begin
        nxt_state = imsre_pkg::IMSRE_BOOT;
      end
    endcase
  end

  always_ff @(posedge clock or posedge rst) begin
    if (rst) begin // [R6]
      state_ff <= imsre_pkg::IMSRE_BOOT;
    end else begin
      state_ff <= nxt_state;
    end
  end

  // ****************************************
  // start-up mode and pll capture
  // ****************************************
  // pins cannot be loaded under async reset, so they are caught at the first edge after release
  always_ff @(posedge clock or posedge rst) begin
    if (rst) begin
      operating_mode_ff <= imsre_pkg::OPMODE_RST;
      pll_enable_ff     <= imsre_pkg::PLL_EN_RST;
    end else if (state_ff == imsre_pkg::IMSRE_BOOT) begin
      operating_mode_ff <= ext_request_n; // [R1]
      pll_enable_ff     <= pll_initial_select; // [R8]
    end
  end

  // ****************************************
  // external requests
  // ****************************************
  // history loads in boot too, so a low mode pin gives no false edge
  always_ff @(posedge clock or posedge rst) begin
    if (rst) begin
      prev_req_ff <= imsre_pkg::PIN_IDLE;
      prev_nmi_ff <= 1'h1;
    end else begin
      prev_req_ff <= ext_request_n;
      prev_nmi_ff <= nmi_n;
    end
  end

  // a new edge in the ack cycle is kept: set wins over clear
  always_comb begin
    nxt_pend = (pend_ff & ~irq_ack) | (req_fell & edge_select & {4{running}}); // [R10]
  end

  always_ff @(posedge clock or posedge rst) begin
    if (rst) begin
      pend_ff <= 4'h0;
    end else begin
      pend_ff <= nxt_pend;
    end
  end

  always_ff @(posedge clock or posedge rst) begin
    if (rst) begin
      irq_request_ff <= 4'h0;
    end else if (running) begin // [R2]
      irq_request_ff <= irq_mask & ((~edge_select & ~ext_request_n) // [R3]
                        | (edge_select & nxt_pend));
    end else begin
      irq_request_ff <= 4'h0;
    end
  end

  // ****************************************
  // non-maskable request
  // ****************************************
  always_ff @(posedge clock or posedge rst) begin
    if (rst) begin
      nmi_request_ff <= 1'h0;
    end else if (running && nmi_fell) begin
      nmi_request_ff <= 1'h1; // [R9]
    end else if (nmi_ack) begin
      nmi_request_ff <= 1'h0;
    end
  end

  // ****************************************
  // wake from low power
  // ****************************************
  // wake ignores the mask: a masked line still ends a standby state
  always_ff @(posedge clock or posedge rst) begin
    if (rst) begin
      wake_ff <= 1'h0;
    end else begin
      wake_ff <= running && (((stop_state || wait_state) && !ext_request_n[0]) // [R4]
                 || (wait_state && (ext_request_n[3:1] != 3'h7))); // [R5]
    end
  end

  // ****************************************
  // phase generator
  // ****************************************
  imsre_phase_gen #(
    .PHASES (imsre_pkg::PHASE_COUNT)
  ) u_phase (
    .clock          (clock),
    .rst            (rst),
    .phase_ff       (phase_ff),
    .phase_start_ff (phase_start_ff)
  );

  // ****************************************
  // checks
  // ****************************************
  default clocking cb @(posedge clock); endclocking
  default disable iff (rst);

  mode_latch_a: assert property (state_ff == imsre_pkg::IMSRE_BOOT |=> // [R1]
      operating_mode_ff == $past(ext_request_n))
    else $error("operating mode not latched at reset release");
  mode_hold_a: assert property (running |=> $stable(operating_mode_ff)) // [R1]
    else $error("operating mode changed after start-up");
  pll_latch_a: assert property (state_ff == imsre_pkg::IMSRE_BOOT |=> // [R8]
      pll_enable_ff == $past(pll_initial_select))
    else $error("pll enable not taken from select pin");
  boot_quiet_a: assert property (state_ff == imsre_pkg::IMSRE_BOOT |=> // [R2]
      irq_request_ff == 4'h0 && !wake_ff)
    else $error("mode pins acted as requests during boot");
  level_req_a: assert property (running // [R3]
      && ((irq_mask & ~edge_select & ~ext_request_n) != 4'h0)
      |=> (irq_request_ff & $past(irq_mask & ~edge_select & ~ext_request_n))
          == $past(irq_mask & ~edge_select & ~ext_request_n))
    else $error("level request not raised");
  masked_req_a: assert property (##1 (irq_request_ff & ~$past(irq_mask)) == 4'h0) // [R3]
    else $error("masked line raised a request");
  edge_pend_a: assert property (running && edge_select[0] && req_fell[0] // [R10]
      |=> pend_ff[0] [*2] or (pend_ff[0] ##1 $past(irq_ack[0])))
    else $error("edge not held pending");
  wake_stop_a: assert property (running && stop_state && !ext_request_n[0] |=> wake_ff) // [R4]
    else $error("request a did not wake from stop");
  wake_wait_a: assert property (running && wait_state && ext_request_n[3:1] != 3'h7 // [R5]
      |=> wake_ff)
    else $error("request b to d did not wake from wait");
  stop_only_a_a: assert property (running && stop_state && !wait_state && ext_request_n[0] // [R5]
      |=> !wake_ff)
    else $error("wake from stop without request a");
  nmi_edge_a: assert property (running && nmi_fell |=> nmi_request_ff) // [R9]
    else $error("nmi edge not raised");

  edge_cov: cover property (running && edge_select[1] && req_fell[1] ##1 pend_ff[1]);
  wake_cov: cover property (stop_state && !ext_request_n[0] ##1 wake_ff);
  nmi_cov:  cover property (nmi_fell ##1 nmi_request_ff ##[1:4] nmi_ack);
  mode_cov: cover property (state_ff == imsre_pkg::IMSRE_BOOT && ext_request_n == 4'ha);

endmodule

// *** test/imsre_src_model.sv ***
// board-side model: power-up reset generator and external request sources
`timescale 1ns/1ps

module imsre_src_model (
  // clock and bench commands
  input  wire logic       clock,
  input  wire logic       reset_req,
  input  wire logic [3:0] want_pins,
  input  wire logic       want_nmi_n,
  input  wire logic       want_pll,
  // pins toward the block
  output logic            rst,
  output logic      [3:0] pins,
  output logic            nmi_n,
  output logic            pll_initial_select
);
  // ****************************************
  // reset generator
  // ****************************************
  // starts loaded, so reset is asserted from power-up for 8 cycles
  logic [3:0] rst_cnt_ff = 4'h8;

  always_ff @(posedge clock) begin
    if (reset_req) begin
      rst_cnt_ff <= 4'h8;
    end else if (rst_cnt_ff != 4'h0) begin
      rst_cnt_ff <= rst_cnt_ff - 4'h1;
    end
  end
  assign rst = (rst_cnt_ff != 4'h0);

  // ****************************************
  // request sources
  // ****************************************
  assign pins               = want_pins;
  assign nmi_n              = want_nmi_n;
  assign pll_initial_select = want_pll;
endmodule

// *** test/irq_mode_select_and_reset_entry_test.sv ***
// self-checking bench for the interrupt and mode control block
`timescale 1ns/1ps

`define CHK(a, b) begin comparisons++; if ((a) !== (b)) begin fail_count++; \
  $display("Error at %0t: got %h expected %h", $time, (a), (b)); end end

module irq_mode_select_and_reset_entry_test;
  logic       clock = 1'h0;
  logic       reset_req = 1'h0, want_nmi_n = 1'h1, want_pll = 1'h0, nmi_ack = 1'h0;
  logic       stop_state = 1'h0, wait_state = 1'h0;
  logic [3:0] want_pins = 4'hf, edge_select = 4'h0, irq_mask = 4'h0, irq_ack = 4'h0;
  logic       rst, nmi_n, pll, pll_enable_ff, nmi_request_ff, wake_ff, phase_ff, phase_start_ff;
  logic [3:0] pins, operating_mode_ff, irq_request_ff;
  int         fail_count = 0, comparisons = 0;

  imsre_src_model src (.clock(clock), .reset_req(reset_req), .want_pins(want_pins),
    .want_nmi_n(want_nmi_n), .want_pll(want_pll), .rst(rst), .pins(pins), .nmi_n(nmi_n),
    .pll_initial_select(pll));

  imsre_top uut (.clock(clock), .rst(rst), .mode_select_a(pins[0]), .mode_select_b(pins[1]),
    .mode_select_c(pins[2]), .mode_select_d(pins[3]), .pll_initial_select(pll),
    .nmi_n(nmi_n), .edge_select(edge_select), .irq_mask(irq_mask), .irq_ack(irq_ack),
    .nmi_ack(nmi_ack), .stop_state(stop_state), .wait_state(wait_state),
    .operating_mode_ff(operating_mode_ff), .pll_enable_ff(pll_enable_ff),
    .irq_request_ff(irq_request_ff), .nmi_request_ff(nmi_request_ff), .wake_ff(wake_ff),
    .phase_ff(phase_ff), .phase_start_ff(phase_start_ff));

  initial begin
    forever #4 clock = ~clock;
  end

  task automatic close_out();
    $display("mismatches %0d, comparisons %0d", fail_count, comparisons);
    if (fail_count == 0 && comparisons > 0) begin
      $display("Testbench passed");
    end else begin
      $display("Testbench failed");
    end
    $finish;
  endtask

  task automatic cyc(input int n);
    repeat (n) @(posedge clock);
    #1;
  endtask

  // reset with a mode code on the shared pins, then check capture and phase restart
  task automatic reset_capture(input logic [3:0] mode, input logic pll_sel);
    @(posedge clock);
    want_pins <= mode;
    want_pll  <= pll_sel;
    reset_req <= 1'h1;
    @(posedge clock);
    reset_req <= 1'h0;
    #1;
    `CHK({operating_mode_ff, pll_enable_ff, irq_request_ff}, 9'h000)
    `CHK({nmi_request_ff, wake_ff, phase_ff, phase_start_ff}, 4'h0)
    for (int i = 0; i < 20 && rst; i++) cyc(1);
    if (rst) begin
      fail_count++;
      close_out();
    end
    cyc(1);
    `CHK(operating_mode_ff, mode)
    `CHK(pll_enable_ff, pll_sel)
    // counter restarts at zero, so the first start pulse lands on the second edge
    `CHK({phase_ff, phase_start_ff}, 2'h0)
    @(posedge clock);
    want_pins <= ~mode;
    want_pll  <= ~pll_sel;
    #1;
    `CHK({phase_ff, phase_start_ff}, 2'h3)
    cyc(1);
    `CHK({phase_ff, phase_start_ff}, 2'h0)
    `CHK(operating_mode_ff, mode)
    `CHK(pll_enable_ff, pll_sel)
    @(posedge clock);
    want_pins <= 4'hf;
    cyc(2);
  endtask

  // level mode on line b: request follows the pin and the mask
  task automatic level_request();
    @(posedge clock);
    edge_select <= 4'h0;
    irq_mask    <= 4'hf;
    want_pins   <= 4'hd;
    cyc(2);
    `CHK(irq_request_ff, 4'h2)
    @(posedge clock);
    irq_mask <= 4'hd;
    cyc(2);
    `CHK(irq_request_ff, 4'h0)
    @(posedge clock);
    want_pins <= 4'hf;
    irq_mask  <= 4'h0;
    cyc(2);
  endtask

  // edge mode on line a: a short low pulse stays pending until acknowledged
  task automatic edge_request();
    @(posedge clock);
    edge_select <= 4'h1;
    irq_mask    <= 4'h0;
    want_pins   <= 4'he;
    @(posedge clock);
    want_pins <= 4'hf;
    cyc(2);
    `CHK(irq_request_ff, 4'h0)
    @(posedge clock);
    irq_mask <= 4'h1;
    cyc(2);
    `CHK(irq_request_ff, 4'h1)
    @(posedge clock);
    irq_ack <= 4'h1;
    @(posedge clock);
    irq_ack <= 4'h0;
    cyc(2);
    `CHK(irq_request_ff, 4'h0)
  endtask

  // nmi falls with every line masked; held until acknowledged
  task automatic nmi_request();
    @(posedge clock);
    irq_mask   <= 4'h0;
    want_nmi_n <= 1'h0;
    cyc(3);
    `CHK(nmi_request_ff, 1'h1)
    @(posedge clock);
    want_nmi_n <= 1'h1;
    nmi_ack    <= 1'h1;
    @(posedge clock);
    nmi_ack <= 1'h0;
    cyc(2);
    `CHK(nmi_request_ff, 1'h0)
  endtask

  // wake from low power: rows of {stop, wait, pins, expected wake}, first row in the low bits
  task automatic wake_table();
    logic [41:0] wk;
    logic [6:0]  row;
    wk = {7'b00_1110_0, 7'b01_0111_1, 7'b01_1011_1,
          7'b10_1101_0, 7'b01_1110_1, 7'b10_1110_1};
    for (int i = 0; i < 6; i++) begin
      row = wk[7*i +: 7];
      @(posedge clock);
      stop_state <= row[6];
      wait_state <= row[5];
      want_pins  <= row[4:1];
      cyc(3);
      `CHK(wake_ff, row[0])
    end
    @(posedge clock);
    want_pins <= 4'hf;
  endtask

  initial begin
    #200000;
    fail_count++;
    close_out();
  end

  initial begin
    cyc(8);
    reset_capture(4'ha, 1'h1);
    reset_capture(4'h5, 1'h0);
    level_request();
    edge_request();
    nmi_request();
    wake_table();
    cyc(2);
    close_out();
  end
endmodule
